// ===== rtl/ucr_pkg.sv
// ucr package: register map, field layout, reset values and timing counts
package ucr_pkg;
  localparam logic [11:0] HCH_MASK_OFF = 12'h050c;
  localparam logic [11:0] HCH_LEN_OFF = 12'h0510;
  localparam logic [11:0] HCH_FLAG_OFF = 12'h0508;
  localparam logic [11:0] DEV_CFG_OFF = 12'h0800;
  localparam logic [11:0] DEV_LOCK_OFF = 12'h0840;
  localparam logic [11:0] DEV_STAT_OFF = 12'h0844;

  localparam int FLG_TOGGLE = 10;
  localparam int FLG_OVERRUN = 9;
  localparam int FLG_BABBLE = 8;
  localparam int FLG_BUSERR = 7;
  localparam int FLG_ACK = 5;
  localparam int FLG_NAK = 4;
  localparam int FLG_STALL = 3;
  localparam int FLG_HALT = 1;
  localparam int FLG_DONE = 0;
  localparam logic [31:0] MASK_VALID = 32'h0000_07bb;

  localparam int LEN_PID_LO = 29;
  localparam int LEN_PACKET_COUNT_LO = 19;
  localparam int LEN_BCNT_LO = 0;
  localparam logic [31:0] LEN_VALID = 32'h7fff_ffff;

  localparam int CFG_EOPT_LO = 11;
  localparam int CFG_ADDR_LO = 4;
  localparam int CFG_NZSTALL = 2;
  localparam int CFG_SPEED_LO = 0;
  localparam logic [31:0] CFG_VALID = 32'h0000_1ff7;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

  localparam logic [1:0] PID_DATA0 = 2'h0;
  localparam logic [1:0] PID_RSVD = 2'h1;
  localparam logic [1:0] PID_DATA1 = 2'h2;
  localparam logic [1:0] PID_SETUP = 2'h3;
  localparam logic [1:0] SPEED_FULL = 2'h3;

  localparam int FRAME_TIME_US = 1000;
  localparam int CLK_MHZ = 10;
  localparam logic [13:0] FRAME_CYC = 14'(FRAME_TIME_US * CLK_MHZ);
  localparam logic [13:0] PERIODIC_FRAME_END_FLAG_80 = 14'(FRAME_TIME_US * CLK_MHZ * 80 / 100);
  localparam logic [13:0] PERIODIC_FRAME_END_FLAG_85 = 14'(FRAME_TIME_US * CLK_MHZ * 85 / 100);
  localparam logic [13:0] PERIODIC_FRAME_END_FLAG_90 = 14'(FRAME_TIME_US * CLK_MHZ * 90 / 100);
  localparam logic [13:0] PERIODIC_FRAME_END_FLAG_95 = 14'(FRAME_TIME_US * CLK_MHZ * 95 / 100);

  typedef struct packed {
    logic [1:0] pid_sel;
    logic [9:0] pkt_cnt;
    logic [18:0] byte_cnt;
  } ucr_len_t;

  typedef struct packed {
    logic toggle_err;
    logic overrun;
    logic babble;
    logic bus_err;
    logic ack;
    logic nak;
    logic stall;
    logic halted;
    logic in_done;
  } ucr_evt_t;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [1:0] pid;
    logic nonzero;
    logic status_out;
  } ucr_tok_t;
endpackage

// ===== rtl/ucr_frame_timer.sv
// ucr frame timer: raises the periodic end-of-frame pulse at a set point
`timescale 1ns/1ps
module ucr_frame_timer #(
  parameter logic [13:0] FRAME_LEN = ucr_pkg::FRAME_CYC
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic sof, // start of frame pulse
  input wire logic [1:0] end_point, // frame end point select
  output logic frame_end // one-cycle end of periodic frame pulse
);
  logic [13:0] cnt_r;
  logic [13:0] cmp;

  always_comb begin
    unique case (end_point)
      2'h0: cmp = ucr_pkg::PERIODIC_FRAME_END_FLAG_80;
      2'h1: cmp = ucr_pkg::PERIODIC_FRAME_END_FLAG_85;
      2'h2: cmp = ucr_pkg::PERIODIC_FRAME_END_FLAG_90;
      2'h3: cmp = ucr_pkg::PERIODIC_FRAME_END_FLAG_95;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 14'h0000;
    end else if (sof || cnt_r == FRAME_LEN - 14'h0001) begin
      cnt_r <= 14'h0000;
    end else begin
      cnt_r <= cnt_r + 14'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_end <= 1'b0;
    end else begin
      frame_end <= (cnt_r == cmp) && !sof;
    end
  end
endmodule

// ===== rtl/ucr_regs.sv
// ucr register slice: channel mask, transfer length, device configuration
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module ucr_regs (
  input wire logic pclk, // bus clock, 10 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire ucr_pkg::ucr_evt_t evt, // host channel event pulses
  input wire logic chan_is_in, // channel direction, 1 = IN
  input wire logic pkt_ok, // data packet transferred without error
  input wire logic tx_fifo_wr, // software wrote one OUT packet
  input wire logic rx_fifo_rd, // software read one IN packet
  input wire logic [10:0] pkt_bytes, // size of that packet
  input wire logic in_pid_valid, // first IN data packet PID seen
  input wire logic [1:0] in_pid, // PID of received IN packet
  output logic [1:0] out_pid, // PID for next OUT data packet
  output logic chan_irq, // channel interrupt level
  input wire ucr_pkg::ucr_tok_t tok, // incoming device token / packet
  output logic addr_match, // token addressed to this device
  output logic status_stall, // answer STALL, drop packet
  input wire logic sof, // start of frame pulse
  output logic frame_end, // end of periodic frame pulse
  output logic [1:0] speed_sel // device speed field
);
  // ****************************************************
  // bus decode
  // ****************************************************
  logic wr_en;
  logic rd_en;
  logic hit;
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  always_comb begin
    unique case (paddr)
      ucr_pkg::HCH_MASK_OFF, ucr_pkg::HCH_LEN_OFF, ucr_pkg::HCH_FLAG_OFF,
      ucr_pkg::DEV_CFG_OFF, ucr_pkg::DEV_LOCK_OFF,
      ucr_pkg::DEV_STAT_OFF: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;

  // ****************************************************
  // channel interrupt mask and flags
  // ****************************************************
  logic [31:0] mask_r;
  logic [31:0] flag_r;
  logic [31:0] flag_set;
  logic [31:0] flag_clr;
  logic tog_err;
  logic done_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= ucr_pkg::RESET_ZERO;
    end else if (wr_en && paddr == ucr_pkg::HCH_MASK_OFF) begin
      mask_r <= pwdata & ucr_pkg::MASK_VALID;
    end
  end

  always_comb begin
    flag_set = 32'h0000_0000;
    flag_set[ucr_pkg::FLG_TOGGLE] = evt.toggle_err || tog_err;
    flag_set[ucr_pkg::FLG_OVERRUN] = evt.overrun;
    flag_set[ucr_pkg::FLG_BABBLE] = evt.babble;
    flag_set[ucr_pkg::FLG_BUSERR] = evt.bus_err;
    flag_set[ucr_pkg::FLG_ACK] = evt.ack;
    flag_set[ucr_pkg::FLG_NAK] = evt.nak;
    flag_set[ucr_pkg::FLG_STALL] = evt.stall;
    flag_set[ucr_pkg::FLG_HALT] = evt.halted;
    flag_set[ucr_pkg::FLG_DONE] = evt.in_done || done_set;
  end
  assign flag_clr = (wr_en && paddr == ucr_pkg::HCH_FLAG_OFF) ?
                    pwdata : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= ucr_pkg::RESET_ZERO;
    end else begin
      // a set in the clearing cycle wins
      flag_r <= ((flag_r & ~flag_clr) | flag_set) &
                ucr_pkg::MASK_VALID;
    end
  end

  assign chan_irq = |(flag_r & mask_r);

  // ****************************************************
  // transfer length
  // ****************************************************
  ucr_pkg::ucr_len_t len_r;
  logic first_pkt_r;
  logic len_wr;
  logic [18:0] dec_bytes;
  assign len_wr = wr_en && paddr == ucr_pkg::HCH_LEN_OFF;
  assign dec_bytes = {8'h00, pkt_bytes};
  assign out_pid = len_r.pid_sel;
  // mismatch only checked on the first IN packet after a load
  assign tog_err = chan_is_in && in_pid_valid && first_pkt_r &&
                   in_pid != len_r.pid_sel;
  assign done_set = chan_is_in && pkt_ok && !tog_err &&
                    len_r.pkt_cnt == 10'h001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_pkt_r <= 1'b0;
    end else if (len_wr) begin
      first_pkt_r <= 1'b1;
    end else if (pkt_ok || in_pid_valid) begin
      first_pkt_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_r <= ucr_pkg::ucr_len_t'(ucr_pkg::RESET_ZERO);
    end else if (len_wr) begin
      len_r <= ucr_pkg::ucr_len_t'(pwdata[30:0]);
    end else begin
      if (pkt_ok) begin
        if (len_r.pkt_cnt != 10'h000) begin
          len_r.pkt_cnt <= len_r.pkt_cnt - 10'h001;
        end
        // setup is followed by data1; data0/1 alternate
        unique case (len_r.pid_sel)
          ucr_pkg::PID_DATA0: len_r.pid_sel <= ucr_pkg::PID_DATA1;
          ucr_pkg::PID_DATA1: len_r.pid_sel <= ucr_pkg::PID_DATA0;
          ucr_pkg::PID_SETUP: len_r.pid_sel <= ucr_pkg::PID_DATA1;
          default: len_r.pid_sel <= len_r.pid_sel;
        endcase
      end
      if ((!chan_is_in && tx_fifo_wr) || (chan_is_in && rx_fifo_rd)) begin
        // saturates at zero rather than wrapping
        len_r.byte_cnt <= (len_r.byte_cnt > dec_bytes) ?
                          len_r.byte_cnt - dec_bytes : 19'h0_0000;
      end
    end
  end

  // ****************************************************
  // device configuration
  // ****************************************************
  logic [31:0] cfg_r;
  logic lock_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r <= 1'b0;
    end else if (wr_en && paddr == ucr_pkg::DEV_LOCK_OFF && pwdata[0]) begin
      lock_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= ucr_pkg::RESET_ZERO;
    end else if (wr_en && paddr == ucr_pkg::DEV_CFG_OFF && !lock_r) begin
      cfg_r <= pwdata & ucr_pkg::CFG_VALID;
    end
  end

  assign speed_sel = cfg_r[ucr_pkg::CFG_SPEED_LO +: 2];
  assign addr_match = tok.valid &&
    tok.addr == cfg_r[ucr_pkg::CFG_ADDR_LO +: 7];
  assign status_stall = addr_match && tok.status_out && tok.nonzero &&
    cfg_r[ucr_pkg::CFG_NZSTALL];

  ucr_frame_timer #(
    .FRAME_LEN(ucr_pkg::FRAME_CYC)
  ) u_frame (
    .pclk(pclk),
    .presetn(presetn),
    .sof(sof),
    .end_point(cfg_r[ucr_pkg::CFG_EOPT_LO +: 2]),
    .frame_end(frame_end)
  );

  // ****************************************************
  // read data
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ucr_pkg::HCH_MASK_OFF: prdata <= mask_r;
        ucr_pkg::HCH_LEN_OFF: prdata <= {1'b0, len_r};
        ucr_pkg::HCH_FLAG_OFF: prdata <= flag_r;
        ucr_pkg::DEV_CFG_OFF: prdata <= cfg_r;
        ucr_pkg::DEV_LOCK_OFF: prdata <= {31'h0000_0000, lock_r};
        ucr_pkg::DEV_STAT_OFF: prdata <= {30'h0000_0000, chan_irq,
                                          speed_sel == ucr_pkg::SPEED_FULL};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ===== tb/ucr_regs_checker.sv
// checker: port-level assertions for the ucr register slice
`timescale 1ns/1ps
module ucr_regs_checker (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] prdata, // apb read data
  input wire logic pslverr, // apb error
  input wire logic pkt_ok, // good packet
  input wire logic [1:0] out_pid, // next OUT pid
  input wire logic sof, // frame start
  input wire logic frame_end // frame end pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, unm;
  assign acc = psel && penable;
  assign unm = !(paddr inside {12'h0508, 12'h050c, 12'h0510, 12'h0800,
    12'h0840, 12'h0844});
  // end pulse must not follow a restart too soon
  sequence s_quiet;
    !frame_end [*8];
  endsequence
  property p_err;
    acc |-> pslverr == unm;
  endproperty
  property p_rdz;
    acc && !pwrite && unm |-> prdata == 32'h0000_0000;
  endproperty
  property p_cfg;
    acc && !pwrite && paddr == 12'h0800 |-> (prdata & ~32'h0000_1ff7) == 0;
  endproperty
  property p_msk;
    acc && !pwrite && paddr == 12'h050c |-> (prdata & ~32'h0000_07bb) == 0;
  endproperty
  property p_rst;
    $rose(presetn) |-> prdata == 32'h0000_0000 && out_pid == 2'h0;
  endproperty
  property p_fend;
    frame_end |=> !frame_end;
  endproperty
  property p_fgap;
    sof |=> s_quiet;
  endproperty
  property p_pid;
    pkt_ok && out_pid == 2'h0 && !(acc && pwrite && paddr == 12'h0510)
      |=> out_pid == 2'h2;
  endproperty
  a_err: assert property (p_err) else $error("slverr wrong");
  a_rdz: assert property (p_rdz) else $error("unmapped read");
  a_cfg: assert property (p_cfg) else $error("cfg reserved");
  a_msk: assert property (p_msk) else $error("mask reserved");
  a_rst: assert property (p_rst) else $error("reset value");
  a_fend: assert property (p_fend) else $error("frame pulse");
  a_fgap: assert property (p_fgap) else $error("frame early");
  a_pid: assert property (p_pid) else $error("pid toggle");
endmodule
bind ucr_regs ucr_regs_checker chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pslverr(pslverr), .pkt_ok(pkt_ok), .out_pid(out_pid),
  .sof(sof), .frame_end(frame_end));

// ===== tb/ucr_usb_model.sv
// usb bus side model: events, packets, fifo strobes, tokens, frames
`timescale 1ns/1ps
module ucr_usb_model (
  input wire logic pclk, // bus clock
  output ucr_pkg::ucr_evt_t evt, // event pulses
  output logic chan_is_in, // channel direction
  output logic pkt_ok, // good packet
  output logic tx_fifo_wr, // OUT packet pushed
  output logic rx_fifo_rd, // IN packet popped
  output logic [10:0] pkt_bytes, // packet size
  output logic in_pid_valid, // IN pid seen
  output logic [1:0] in_pid, // IN pid
  output ucr_pkg::ucr_tok_t tok, // token
  output logic sof // frame start
);
  initial begin
    {evt, chan_is_in, pkt_ok, tx_fifo_wr, rx_fifo_rd, in_pid_valid} = '0;
    {pkt_bytes, in_pid, tok, sof} = '0;
  end
  // size and pid lines flip once released so nothing stale is seen
  task automatic go(input logic [4:0] k, input logic [8:0] e,
      input logic [10:0] b, input logic [1:0] p);
    {pkt_ok, tx_fifo_wr, rx_fifo_rd, in_pid_valid, sof} <= k;
    evt <= e;
    pkt_bytes <= b;
    in_pid <= p;
    @(posedge pclk);
    {pkt_ok, tx_fifo_wr, rx_fifo_rd, in_pid_valid, sof} <= '0;
    evt <= '0;
    pkt_bytes <= ~b;
    in_pid <= ~p;
    @(posedge pclk);
  endtask
endmodule

// ===== tb/ucr_regs_tb.sv
// self-checking bench for the ucr register slice
`timescale 1ns/1ps
module ucr_regs_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, pkt_ok, tx_fifo_wr, rx_fifo_rd, in_pid_valid, sof;
  logic chan_is_in, chan_irq, addr_match, status_stall, frame_end;
  logic [10:0] pkt_bytes;
  logic [1:0] in_pid, out_pid, speed_sel;
  ucr_pkg::ucr_evt_t evt;
  ucr_pkg::ucr_tok_t tok;
  int failures = 0, comparisons = 0, cyc = 0;
  always #50 pclk = ~pclk;
  ucr_usb_model m_u (.pclk(pclk), .evt(evt), .chan_is_in(chan_is_in),
    .pkt_ok(pkt_ok), .tx_fifo_wr(tx_fifo_wr), .rx_fifo_rd(rx_fifo_rd),
    .pkt_bytes(pkt_bytes), .in_pid_valid(in_pid_valid), .in_pid(in_pid),
    .tok(tok), .sof(sof));
  ucr_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
    .chan_is_in(chan_is_in), .pkt_ok(pkt_ok), .tx_fifo_wr(tx_fifo_wr),
    .rx_fifo_rd(rx_fifo_rd), .pkt_bytes(pkt_bytes), .in_pid(in_pid),
    .in_pid_valid(in_pid_valid), .out_pid(out_pid), .chan_irq(chan_irq),
    .tok(tok), .addr_match(addr_match), .status_stall(status_stall),
    .sof(sof), .frame_end(frame_end), .speed_sel(speed_sel));
  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // extra idle edge after release lets registered outputs land
  // only the bench timeout ends a wait for ready
  task automatic apb(input logic [11:0] a, input logic w, input [31:0] d);
    {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end
  task automatic t_mask;
    int pos[9] = '{0, 1, 3, 4, 5, 7, 8, 9, 10};
    logic [31:0] b;
    apb(12'h0800, 0, 0);
    chk("cfg rst", 0, q);
    apb(12'h0604, 0, 0);
    chk("unmapped", 1, err);
    apb(12'h050c, 1, 32'hffff_ffff);
    apb(12'h050c, 0, 0);
    chk("mask rw", 32'h0000_07bb, q);
    for (int j = 0; j < 9; j++) begin
      b = 32'h1 << pos[j];
      apb(12'h050c, 1, 32'h0000_07bb & ~b);
      m_u.go(0, 9'h001 << j, 0, 0);
      chk("irq masked", 0, chan_irq);
      apb(12'h0508, 0, 0);
      chk("flag", b, q);
      apb(12'h050c, 1, b);
      chk("irq on", 1, chan_irq);
      apb(12'h0508, 1, b);
      chk("irq off", 0, chan_irq);
    end
    apb(12'h050c, 0, 0);
    chk("mask kept", b, q);
    $display("mask test done");
  endtask
  task automatic t_len;
    logic [1:0] c[3] = '{2'h0, 2'h2, 2'h3};
    foreach (c[i]) begin
      apb(12'h0510, 1, {1'b0, c[i], 10'h002, 19'h0_0064});
      chk("out pid", c[i], out_pid);
    end
    m_u.go(5'h08, 0, 11'h040, 0);
    m_u.go(5'h10, 0, 0, 0);
    apb(12'h0510, 0, 0);
    chk("out len", {3'h2, 10'h001, 19'h0_0024}, q);
    m_u.chan_is_in <= 1;
    apb(12'h0510, 1, {3'h0, 10'h001, 19'h0_0040});
    m_u.go(5'h02, 0, 0, 2'h2);
    m_u.go(5'h04, 0, 11'h040, 0);
    m_u.go(5'h10, 0, 0, 0);
    apb(12'h0508, 0, 0);
    chk("in flags", 32'h0000_0401, q);
    apb(12'h0510, 0, 0);
    chk("in len", {3'h2, 29'h0}, q);
    $display("length test done");
  endtask
  task automatic t_cfg;
    int n;
    apb(12'h0800, 1, 32'hffff_eaaf);
    apb(12'h0800, 0, 0);
    chk("cfg rw", 32'h0000_0aa7, q);
    chk("speed", 2'h3, speed_sel);
    m_u.tok <= 12'h0aa0;
    @(posedge pclk);
    chk("match", 1, addr_match);
    m_u.tok <= 12'h0ab0;
    @(posedge pclk);
    chk("no match", 0, addr_match);
    m_u.tok <= 12'h0aa3;
    @(posedge pclk);
    chk("stall", 1, status_stall);
    m_u.tok <= 12'h0550;
    m_u.go(5'h01, 0, 0, 0);
    n = 1;
    while (frame_end !== 1'b1 && n < 9600) begin
      @(posedge pclk);
      n++;
    end
    chk("frame end", 1, n > 8498 && n < 8503);
    apb(12'h0840, 1, 1);
    apb(12'h0800, 1, 0);
    apb(12'h0800, 0, 0);
    chk("cfg locked", 32'h0000_0aa7, q);
    apb(12'h0840, 0, 0);
    chk("lock", 1, q);
    apb(12'h0844, 0, 0);
    chk("status", 32'h0000_0003, q);
    $display("config test done");
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_mask();
    t_len();
    t_cfg();
    close_out();
  end
endmodule
